// ---- logic/dtc_map.svh ----
/*
 Timing counts, field codes and reset values for the dual timer/counter block.
 Assumes a 25 MHz core clock; included by bare name.
*/
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_CLK_HZ 25000000
`define DTC_CLK_NS 40
`define DTC_WIN_MS 839
`define DTC_WIN_CYC ((`DTC_CLK_HZ / 1000) * `DTC_WIN_MS)
`define DTC_MIN_NS 200
`define DTC_MIN_CYC ((`DTC_MIN_NS + `DTC_CLK_NS - 1) / `DTC_CLK_NS)
`define DTC_QUAD_MAX 16'h3FFF
`define DTC_QUAD_MIN 16'hC001
`define DTC_CNT_MAX 16'hFFFF
`define DTC_LOAD_RST 16'h0000
`define DTC_PRE_BITS 4
`endif

// ---- logic/dtc_pkg.sv ----
/*
 Types for the dual timer/counter block.
 Assumes the map header is compiled alongside.
*/
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_EDGE_RISE = 2'b00,
        DTC_EDGE_FALL = 2'b01,
        DTC_EDGE_BOTH = 2'b10,
        DTC_EDGE_NONE = 2'b11
    } dtc_edge_type;
    typedef enum logic [3:0] {
        DTC_MODE_OFF = 4'b0000,
        DTC_MODE_TOTAL = 4'b0001,
        DTC_MODE_PCOUNT = 4'b0010,
        DTC_MODE_ONTIME = 4'b0011,
        DTC_MODE_PERIOD = 4'b0100,
        DTC_MODE_QUAD = 4'b0101,
        DTC_MODE_FREQ = 4'b0110,
        DTC_MODE_PWIDTH = 4'b0111,
        DTC_MODE_ONESHOT = 4'b1000,
        DTC_MODE_EDGEDIV = 4'b1001,
        DTC_MODE_EDGELOG = 4'b1010
    } dtc_mode_type;
endpackage : dtc_pkg

// ---- logic/dtc_unit.sv ----
/*
 One 16-bit timer/counter: load register, counter, capture latch, output.
 Assumes synchronous pin inputs and byte accesses from the CPU side.
*/
`include "dtc_map.svh"
module dtc_unit
    import dtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire dtc_mode_type mode,
    input wire dtc_edge_type edge_sel,
    input wire logic use_pin_clk,
    input wire logic [3:0] pre_sel,
    input wire logic [3:0] pre_cnt,
    input wire logic win_tick,
    input wire logic in_a,
    input wire logic in_b,
    input wire logic load_wr_lo,
    input wire logic load_wr_hi,
    input wire logic [7:0] wr_byte,
    input wire logic rd_lo,
    input wire logic rd_hi,
    input wire logic trigger,
    output logic [7:0] rd_byte,
    output logic out_q,
    output logic out_en,
    output logic cap_pulse
);
    logic [15:0] load_q;
    logic [15:0] cnt_q;
    logic [15:0] latch_q;
    logic [7:0] hi_hold_q;
    logic [7:0] rd_byte_q;
    logic a_q;
    logic b_q;
    logic rise;
    logic fall;
    logic pin_ev;
    logic tick;
    logic in_mode;
    logic cap_q;
    logic busy_q;
    logic [1:0] quad_dir;

    assign rise = in_a & ~a_q;
    assign fall = ~in_a & a_q;
    always_comb
    begin
        unique case (edge_sel)
            DTC_EDGE_RISE: pin_ev = rise;
            DTC_EDGE_FALL: pin_ev = fall;
            DTC_EDGE_BOTH: pin_ev = rise | fall;
            DTC_EDGE_NONE: pin_ev = 1'b0;
        endcase
    end
    // Pin edge or prescaled system clock
    assign tick = use_pin_clk ? pin_ev : (pre_cnt == pre_sel);
    assign in_mode = (mode != DTC_MODE_FREQ) && (mode != DTC_MODE_PWIDTH) &&
        (mode != DTC_MODE_ONESHOT) && (mode != DTC_MODE_EDGEDIV) && (mode != DTC_MODE_OFF);
    // Output pin driven only in output modes, left free otherwise
    assign out_en = ~in_mode & (mode != DTC_MODE_OFF);
    assign quad_dir = {in_a ^ a_q, in_b ^ b_q};

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end
        else
        begin
            a_q <= in_a;
            b_q <= in_b;
        end
    end

    // CPU-writable load register, byte wide halves
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            load_q <= `DTC_LOAD_RST;
        else if (load_wr_lo)
            load_q[7:0] <= wr_byte;
        else if (load_wr_hi)
            load_q[15:8] <= wr_byte;
    end

    // Counter and hardware capture
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= 16'h0000;
            latch_q <= 16'h0000;
            cap_q <= 1'b0;
            busy_q <= 1'b0;
            out_q <= 1'b0;
        end
        else
        begin
            cap_q <= 1'b0;
            unique case (mode)
                DTC_MODE_OFF:
                begin
                    cnt_q <= 16'h0000;
                    out_q <= 1'b0;
                end
                DTC_MODE_TOTAL:
                begin
                    if (pin_ev && cnt_q != `DTC_CNT_MAX)
                        cnt_q <= cnt_q + 16'h0001;
                    latch_q <= cnt_q;
                end
                DTC_MODE_PCOUNT:
                begin
                    if (win_tick)
                    begin
                        latch_q <= cnt_q;
                        cap_q <= 1'b1;
                        cnt_q <= {15'h0000, pin_ev};
                    end
                    else if (pin_ev && cnt_q != `DTC_CNT_MAX)
                        cnt_q <= cnt_q + 16'h0001;
                end
                DTC_MODE_ONTIME, DTC_MODE_PERIOD:
                begin
                    // On-time ends when the pin leaves its active level
                    if ((mode == DTC_MODE_PERIOD) ? pin_ev :
                        (busy_q && (in_a ^ a_q) && in_a == edge_sel[0]))
                    begin
                        latch_q <= cnt_q;
                        cap_q <= 1'b1;
                        cnt_q <= 16'h0000;
                        busy_q <= (mode == DTC_MODE_PERIOD);
                    end
                    else if ((mode == DTC_MODE_PERIOD || in_a == ~edge_sel[0]) && pin_ev)
                    begin
                        busy_q <= 1'b1;
                        cnt_q <= 16'h0000;
                    end
                    else if (busy_q && tick && cnt_q != `DTC_CNT_MAX &&
                             (mode == DTC_MODE_PERIOD || in_a != edge_sel[0]))
                        cnt_q <= cnt_q + 16'h0001;
                end
                DTC_MODE_QUAD:
                begin
                    // Gray-code step; direction from which phase moved
                    if (quad_dir == 2'b10)
                    begin
                        if ((in_a ^ in_b) && cnt_q != `DTC_QUAD_MAX)
                            cnt_q <= cnt_q + 16'h0001;
                        else if (!(in_a ^ in_b) && cnt_q != `DTC_QUAD_MIN)
                            cnt_q <= cnt_q - 16'h0001;
                    end
                    else if (quad_dir == 2'b01)
                    begin
                        if (!(in_a ^ in_b) && cnt_q != `DTC_QUAD_MAX)
                            cnt_q <= cnt_q + 16'h0001;
                        else if ((in_a ^ in_b) && cnt_q != `DTC_QUAD_MIN)
                            cnt_q <= cnt_q - 16'h0001;
                    end
                    latch_q <= cnt_q;
                end
                DTC_MODE_FREQ, DTC_MODE_EDGEDIV:
                begin
                    if (tick)
                    begin
                        if (cnt_q == 16'h0000)
                        begin
                            cnt_q <= load_q;
                            out_q <= (load_q != 16'h0000) ? ~out_q : 1'b0;
                        end
                        else
                            cnt_q <= cnt_q - 16'h0001;
                    end
                end
                DTC_MODE_PWIDTH:
                begin
                    if (tick)
                        cnt_q <= cnt_q + 16'h0001;
                    // High while counter below load: 0 gives 0%, full gives 100%
                    out_q <= (load_q == `DTC_CNT_MAX) | (cnt_q < load_q);
                end
                DTC_MODE_ONESHOT:
                begin
                    if (trigger && !busy_q)
                    begin
                        busy_q <= (load_q != 16'h0000);
                        cnt_q <= load_q;
                        out_q <= (load_q != 16'h0000);
                    end
                    else if (busy_q && tick)
                    begin
                        if (cnt_q == 16'h0001)
                        begin
                            busy_q <= 1'b0;
                            out_q <= 1'b0;
                        end
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                DTC_MODE_EDGELOG:
                begin
                    if (pin_ev)
                    begin
                        latch_q <= cnt_q;
                        cap_q <= 1'b1;
                        cnt_q <= 16'h0000;
                    end
                    else if (tick && cnt_q != `DTC_CNT_MAX)
                        cnt_q <= cnt_q + 16'h0001;
                end
                default:
                    cnt_q <= 16'h0000;
            endcase
        end
    end
    assign cap_pulse = cap_q;

    // Low-byte read freezes the high byte for the following read
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hi_hold_q <= 8'h00;
            rd_byte_q <= 8'h00;
        end
        else if (rd_lo)
        begin
            hi_hold_q <= latch_q[15:8];
            rd_byte_q <= latch_q[7:0];
        end
        else if (rd_hi)
            rd_byte_q <= hi_hold_q;
    end
    assign rd_byte = rd_byte_q;
endmodule : dtc_unit

// ---- logic/dtc_top.sv ----
/*
 Dual 16-bit timer/counter with pin allocation among general pins 0, 1, 4..7.
 Assumes pins and CPU strobes synchronous to core_clk; software keeps function
 assignment rules for the pin configuration.
*/
`include "dtc_map.svh"
// Summary of operation
// - Two 16-bit timer/counters with independently chosen clock sources.
// - First unit input muxed from pins 4..7; output on pin 0.
// - Second unit input from pin 4; output on pin 1.
// - Each unit has writable load register, counter, readable latch.
// - Load register and latch are accessed one byte at a time.
// - Unit drives its output pin only when it runs an output function.
// - Unit clock from pin edges or prescaled system clock.
// - Pin clocking on rising, falling or both edges.
// - First unit time-shares up to four inputs via its multiplexer.
// - Edge logging takes both units; nothing else runs then.
// - Parallel port owns pins; pin 11 bit or interrupt request.
// - Timer pin direction overrides overlaid direct-level use.
// - Quadrature on pins 4/5 or 6/7, signed count within 16383.
// - Pulse count over 0.839 s window, total count, 0..65535.
// - On-time, period and one-shot cover 0.2 us to 41.94 ms.
// - Square wave output and 0..100% duty pulse train.
// - Edge divide toggles at input rate over load value plus one.
// - Hardware captures measurements independently of the processor.
module dtc_top
    import dtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:4] gpin_in,
    input wire logic [1:0] direct_out,
    input wire logic [1:0] direct_oe,
    input wire logic par_active,
    input wire logic par_slave_b,
    input wire logic par_irq,
    input wire logic bit11_out,
    input wire logic bit11_oe,
    input wire dtc_mode_type mode1,
    input wire dtc_mode_type mode2,
    input wire dtc_edge_type edge1,
    input wire dtc_edge_type edge2,
    input wire logic pin_clk1,
    input wire logic pin_clk2,
    input wire logic [3:0] pre1,
    input wire logic [3:0] pre2,
    input wire logic [1:0] mux_sel,
    input wire logic quad_upper,
    input wire logic [1:0] load_wr_lo,
    input wire logic [1:0] load_wr_hi,
    input wire logic [7:0] wr_byte,
    input wire logic [1:0] rd_lo,
    input wire logic [1:0] rd_hi,
    input wire logic [1:0] trigger,
    output logic [7:0] rd_byte1,
    output logic [7:0] rd_byte2,
    output logic general_pin_0,
    output logic general_pin_0_oe,
    output logic general_pin_1,
    output logic general_pin_1_oe,
    output logic general_pin_11,
    output logic general_pin_11_oe,
    output logic [1:0] cap_pulse,
    output logic edgelog_active
);
    logic [`DTC_PRE_BITS-1:0] pre_q;
    logic [25:0] win_q;
    logic win_tick;
    logic in1_a;
    logic in1_b;
    logic [1:0] t_out;
    logic [1:0] t_oe;
    logic log_mode;
    dtc_mode_type m1;
    dtc_mode_type m2;

    // Shared free-running prescaler
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            pre_q <= '0;
        else
            pre_q <= pre_q + 4'h1;
    end

    // Fixed pulse-count window
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            win_q <= 26'h0000000;
        else if (win_q == 26'(`DTC_WIN_CYC - 1))
            win_q <= 26'h0000000;
        else
            win_q <= win_q + 26'h0000001;
    end
    assign win_tick = (win_q == 26'(`DTC_WIN_CYC - 1));

    // Edge logging claims both units
    assign log_mode = (mode1 == DTC_MODE_EDGELOG) || (mode2 == DTC_MODE_EDGELOG);
    assign m1 = log_mode ? DTC_MODE_EDGELOG : mode1;
    assign m2 = log_mode ? DTC_MODE_OFF : mode2;
    assign edgelog_active = log_mode;

    // Input multiplexer of the first unit
    always_comb
    begin
        in1_a = gpin_in[4];
        in1_b = gpin_in[5];
        if (m1 == DTC_MODE_QUAD)
        begin
            in1_a = quad_upper ? gpin_in[6] : gpin_in[4];
            in1_b = quad_upper ? gpin_in[7] : gpin_in[5];
        end
        else if (!log_mode)
            in1_a = gpin_in[3'd4 + {1'b0, mux_sel}];
    end

    dtc_unit u_tc1 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .mode(m1),
        .edge_sel(log_mode ? DTC_EDGE_BOTH : edge1),
        .use_pin_clk(pin_clk1),
        .pre_sel(pre1),
        .pre_cnt(pre_q),
        .win_tick(win_tick),
        .in_a(in1_a),
        .in_b(in1_b),
        .load_wr_lo(load_wr_lo[0]),
        .load_wr_hi(load_wr_hi[0]),
        .wr_byte(wr_byte),
        .rd_lo(rd_lo[0]),
        .rd_hi(rd_hi[0]),
        .trigger(trigger[0]),
        .rd_byte(rd_byte1),
        .out_q(t_out[0]),
        .out_en(t_oe[0]),
        .cap_pulse(cap_pulse[0])
    );

    dtc_unit u_tc2 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .mode(m2),
        .edge_sel(edge2),
        .use_pin_clk(pin_clk2),
        .pre_sel(pre2),
        .pre_cnt(pre_q),
        .win_tick(win_tick),
        .in_a(gpin_in[4]),
        .in_b(gpin_in[5]),
        .load_wr_lo(load_wr_lo[1]),
        .load_wr_hi(load_wr_hi[1]),
        .wr_byte(wr_byte),
        .rd_lo(rd_lo[1]),
        .rd_hi(rd_hi[1]),
        .trigger(trigger[1]),
        .rd_byte(rd_byte2),
        .out_q(t_out[1]),
        .out_en(t_oe[1]),
        .cap_pulse(cap_pulse[1])
    );

    // Timer direction wins over direct-level use; parallel port owns pins
    always_comb
    begin
        general_pin_0 = t_oe[0] ? t_out[0] : direct_out[0];
        general_pin_0_oe = ~par_active & (t_oe[0] | direct_oe[0]);
        general_pin_1 = t_oe[1] ? t_out[1] : direct_out[1];
        general_pin_1_oe = ~par_active & (t_oe[1] | direct_oe[1]);
        general_pin_11 = (par_active & par_slave_b) ? par_irq : bit11_out;
        general_pin_11_oe = (par_active & par_slave_b) | bit11_oe;
    end
endmodule : dtc_top

// ---- tb/dtc_sva.sv ----
/*
 Port checks for the dual timer/counter top.
 Assumes one core clock and the asynchronous active-low reset.
*/
module dtc_sva
    import dtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [1:0] direct_out,
    input wire logic [1:0] direct_oe,
    input wire logic par_active,
    input wire logic par_slave_b,
    input wire logic par_irq,
    input wire logic bit11_out,
    input wire logic bit11_oe,
    input wire dtc_mode_type mode1,
    input wire dtc_mode_type mode2,
    input wire logic [1:0] rd_lo,
    input wire logic [1:0] rd_hi,
    input wire logic [7:0] rd_byte1,
    input wire logic general_pin_0,
    input wire logic general_pin_0_oe,
    input wire logic general_pin_1,
    input wire logic general_pin_1_oe,
    input wire logic general_pin_11,
    input wire logic general_pin_11_oe,
    input wire logic [1:0] cap_pulse,
    input wire logic edgelog_active
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv1;
    logic drv2;
    // Unit owns its pin only in an output mode outside edge logging
    assign drv1 = !edgelog_active && (mode1 inside {DTC_MODE_FREQ, DTC_MODE_PWIDTH,
        DTC_MODE_ONESHOT, DTC_MODE_EDGEDIV});
    assign drv2 = !edgelog_active && (mode2 inside {DTC_MODE_FREQ, DTC_MODE_PWIDTH,
        DTC_MODE_ONESHOT, DTC_MODE_EDGEDIV});
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    property p_par_oe; par_active |-> !general_pin_0_oe && !general_pin_1_oe; endproperty
    a_par_oe: assert property (p_par_oe) else $error("pin 0/1 driven by parallel");
    property p_elog; edgelog_active == (mode1 == DTC_MODE_EDGELOG || mode2 == DTC_MODE_EDGELOG);
    endproperty
    a_elog: assert property (p_elog) else $error("edge log flag wrong");
    property p_pin0_free; !par_active && !drv1 |-> general_pin_0_oe == direct_oe[0]
        && (!direct_oe[0] || general_pin_0 == direct_out[0]); endproperty
    a_pin0_free: assert property (p_pin0_free) else $error("pin 0 not free");
    property p_pin0_tmr; !par_active && drv1 |-> general_pin_0_oe; endproperty
    a_pin0_tmr: assert property (p_pin0_tmr) else $error("pin 0 not driven");
    property p_pin1_free; !par_active && !drv2 |-> general_pin_1_oe == direct_oe[1]
        && (!direct_oe[1] || general_pin_1 == direct_out[1]); endproperty
    a_pin1_free: assert property (p_pin1_free) else $error("pin 1 not free");
    property p_pin1_tmr; !par_active && drv2 |-> general_pin_1_oe; endproperty
    a_pin1_tmr: assert property (p_pin1_tmr) else $error("pin 1 not driven");
    property p_irq; par_active && par_slave_b |-> general_pin_11_oe && general_pin_11 == par_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("pin 11 not request");
    property p_bit11; !(par_active && par_slave_b) |-> general_pin_11_oe == bit11_oe
        && (!bit11_oe || general_pin_11 == bit11_out); endproperty
    a_bit11: assert property (p_bit11) else $error("pin 11 bit wrong");
    property p_rd_hold; !rd_lo[0] && !rd_hi[0] |=> $stable(rd_byte1); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read byte moved");
    property p_hi_held; rd_hi[0] && !rd_lo[0] ##1 rd_hi[0] && !rd_lo[0]
        |=> rd_byte1 == $past(rd_byte1); endproperty
    a_hi_held: assert property (p_hi_held) else $error("high byte not held");
    property p_cap_one; cap_pulse[0] && !edgelog_active |=> !cap_pulse[0]; endproperty
    a_cap_one: assert property (p_cap_one) else $error("capture pulse long");
    c_cap: cover property (cap_pulse[0]);
    c_elog: cover property (edgelog_active);
    c_pair: cover property (rd_lo[0] ##1 rd_hi[0]);
endmodule : dtc_sva
bind dtc_top dtc_sva u_dtc_sva (.core_clk, .rst_b, .direct_out, .direct_oe, .par_active,
    .par_slave_b, .par_irq, .bit11_out, .bit11_oe, .mode1, .mode2, .rd_lo, .rd_hi, .rd_byte1,
    .general_pin_0, .general_pin_0_oe, .general_pin_1, .general_pin_1_oe, .general_pin_11,
    .general_pin_11_oe, .cap_pulse, .edgelog_active);

// ---- tb/dtc_sensor.sv ----
/*
 Sensor and encoder model driving general pins 4..7.
 Assumes the bench calls its tasks; levels change on the falling edge.
*/
module dtc_sensor
(
    input wire logic core_clk,
    output logic [7:4] gpin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] qs [2] = '{2'h0, 2'h0};
    initial gpin = 4'h0;
    // Pulses two cycles high, two low
    task automatic pulses(input int p, input int n);
        repeat (n)
        begin
            @(negedge core_clk) gpin[p] = 1'b1;
            repeat (2) @(negedge core_clk);
            gpin[p] = 1'b0;
            @(negedge core_clk);
        end
    endtask : pulses
    task automatic hold(input int p, input int c);
        @(negedge core_clk) gpin[p] = 1'b1;
        repeat (c) @(negedge core_clk);
        gpin[p] = 1'b0;
    endtask : hold
    // Gray code steps, one every two cycles
    task automatic quad(input int hi, input int n, input bit up);
        repeat (n)
        begin
            @(negedge core_clk) qs[hi] = qs[hi] + (up ? 2'h1 : 2'h3);
            {gpin[4 + 2 * hi], gpin[5 + 2 * hi]} = qs[hi] ^ {1'b0, qs[hi][1]};
            @(negedge core_clk);
        end
    endtask : quad
endmodule : dtc_sensor

// ---- tb/testbench.sv ----
/*
 Self-checking bench for the dual timer/counter top.
 Assumes inputs change on the falling edge and pin allocation stays legal.
*/
module testbench
    import dtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic par_active, par_slave_b, par_irq, bit11_out, bit11_oe, pin_clk1, pin_clk2;
    logic quad_upper, general_pin_0, general_pin_0_oe, general_pin_1, general_pin_1_oe;
    logic general_pin_11, general_pin_11_oe, edgelog_active;
    logic [1:0] direct_out, direct_oe, mux_sel, load_wr_lo, load_wr_hi, rd_lo, rd_hi;
    logic [1:0] trigger, cap_pulse;
    logic [3:0] pre1, pre2;
    logic [7:4] gpin_in;
    logic [7:0] wr_byte, rd_byte1, rd_byte2;
    dtc_mode_type mode1, mode2;
    dtc_edge_type edge1, edge2;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    always #20 core_clk = ~core_clk;
    dtc_top u_dtc_top (.core_clk, .rst_b, .gpin_in, .direct_out, .direct_oe, .par_active,
        .par_slave_b, .par_irq, .bit11_out, .bit11_oe, .mode1, .mode2, .edge1, .edge2,
        .pin_clk1, .pin_clk2, .pre1, .pre2, .mux_sel, .quad_upper, .load_wr_lo, .load_wr_hi,
        .wr_byte, .rd_lo, .rd_hi, .trigger, .rd_byte1, .rd_byte2, .general_pin_0,
        .general_pin_0_oe, .general_pin_1, .general_pin_1_oe, .general_pin_11,
        .general_pin_11_oe, .cap_pulse, .edgelog_active);
    dtc_sensor u_dtc_sensor (.core_clk, .gpin(gpin_in));
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] edges(input dtc_edge_type e, input int n);
        return (e == DTC_EDGE_BOTH) ? 16'(2 * n) : 16'(n);
    endfunction : edges
    // Low byte, then high byte twice
    task automatic rd(input int u, output logic [15:0] v);
        @(negedge core_clk) rd_lo[u] = 1'b1;
        @(negedge core_clk) rd_lo[u] = 1'b0;
        v[7:0] = u ? rd_byte2 : rd_byte1;
        rd_hi[u] = 1'b1;
        @(negedge core_clk) v[15:8] = u ? rd_byte2 : rd_byte1;
        @(negedge core_clk) rd_hi[u] = 1'b0;
        chk({8'h00, u ? rd_byte2 : rd_byte1}, {8'h00, v[15:8]});
    endtask : rd
    task automatic wr(input int u, input logic [15:0] v);
        @(negedge core_clk) load_wr_lo[u] = 1'b1;
        wr_byte = v[7:0];
        @(negedge core_clk) load_wr_lo[u] = 1'b0;
        load_wr_hi[u] = 1'b1;
        wr_byte = v[15:8];
        @(negedge core_clk) load_wr_hi[u] = 1'b0;
    endtask : wr
    task automatic rst();
        @(negedge core_clk) rst_b = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
    endtask : rst
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    initial
    begin
        logic [15:0] v;
        logic p;
        int n;
        int k;
        {par_active, par_slave_b, par_irq, bit11_out, bit11_oe, quad_upper} = 6'h00;
        {direct_out, direct_oe, mux_sel, load_wr_lo, load_wr_hi, rd_lo, rd_hi, trigger} = 16'h0000;
        {pin_clk1, pin_clk2, pre1, pre2, wr_byte} = 18'h00000;
        mode1 = DTC_MODE_OFF;
        mode2 = DTC_MODE_OFF;
        edge1 = DTC_EDGE_RISE;
        edge2 = DTC_EDGE_RISE;
        void'($urandom(11));
        for (int e = 0; e < 3; e++)
            for (int m = 0; m < 4; m++)
            begin
                rst();
                {direct_out, direct_oe, pre2} = 8'($urandom);
                mode1 = DTC_MODE_TOTAL;
                mode2 = DTC_MODE_TOTAL;
                edge1 = dtc_edge_type'(e);
                edge2 = dtc_edge_type'(2 - e);
                {pin_clk1, pin_clk2, mux_sel} = {2'h3, 2'(m)};
                n = $urandom_range(20, 1);
                u_dtc_sensor.pulses(4 + m, n);
                repeat (4) @(negedge core_clk);
                rd(0, v);
                chk(v, edges(edge1, n));
                rd(1, v);
                chk(v, edges(edge2, m == 0 ? n : 0));
                $display("total count edge %0d pin %0d done", e, 4 + m);
            end
        for (int q = 0; q < 2; q++)
        begin
            rst();
            mode1 = DTC_MODE_QUAD;
            quad_upper = 1'(q);
            n = $urandom_range(40, 5);
            u_dtc_sensor.quad(q, n, 1'b1);
            repeat (4) @(negedge core_clk);
            rd(0, v);
            chk((v == 16'(n) || v == 16'(-n)) ? 16'(n) : v, 16'(n));
            u_dtc_sensor.quad(q, n, 1'b0);
            repeat (4) @(negedge core_clk);
            rd(0, v);
            chk(v, 16'h0000);
            $display("quadrature pair %0d done", q);
        end
        rst();
        mode1 = DTC_MODE_ONTIME;
        edge1 = DTC_EDGE_RISE;
        {pin_clk1, mux_sel, pre1} = {3'h1, 4'($urandom)};
        k = $urandom_range(10, 3);
        u_dtc_sensor.hold(5, 16 * k);
        for (n = 0; n < 40 && cap_pulse[0] !== 1'b1; n++)
            @(negedge core_clk);
        chk(16'(n < 40), 16'h0001);
        rd(0, v);
        chk((v >= 16'(k - 1) && v <= 16'(k + 1)) ? 16'(k) : v, 16'(k));
        $display("on time done");
        mode1 = DTC_MODE_PWIDTH;
        direct_oe = 2'h3;
        for (int i = 0; i < 2; i++)
        begin
            wr(0, i ? 16'h0000 : 16'hFFFF);
            repeat (40) @(negedge core_clk);
            chk({15'h0000, general_pin_0}, 16'(i == 0));
            chk({15'h0000, general_pin_0_oe}, 16'h0001);
        end
        $display("pulse width done");
        for (int i = 0; i < 2; i++)
        begin
            {par_active, par_slave_b, par_irq, bit11_out, bit11_oe} = {2'(i) + 2'h2, 2'($urandom), 1'b1};
            @(negedge core_clk);
            chk({15'h0000, general_pin_0_oe}, 16'h0000);
            chk({15'h0000, general_pin_11}, {15'h0000, i ? par_irq : bit11_out});
        end
        $display("parallel port done");
        par_active = 1'b0;
        rst();
        mux_sel = 2'h0;
        mode1 = DTC_MODE_EDGELOG;
        mode2 = DTC_MODE_FREQ;
        wr(1, 16'h0002);
        k = 0;
        fork
            u_dtc_sensor.pulses(4, 2);
            repeat (12)
            begin
                @(negedge core_clk);
                k += int'(cap_pulse[0] === 1'b1);
            end
        join
        chk({15'h0000, edgelog_active}, 16'h0001);
        chk(16'(k), 16'h0004);
        $display("edge log done");
        rst();
        mode1 = DTC_MODE_EDGEDIV;
        {pin_clk1, mux_sel} = 3'h6;
        wr(0, 16'h0003);
        k = 0;
        p = general_pin_0;
        fork
            u_dtc_sensor.pulses(6, 40);
            repeat (170)
            begin
                @(negedge core_clk);
                k += int'(general_pin_0 !== p);
                p = general_pin_0;
            end
        join
        chk((k >= 9 && k <= 11) ? 16'h000A : 16'(k), 16'h000A);
        $display("edge divide done");
        rst();
        mode2 = DTC_MODE_ONESHOT;
        {pin_clk2, pre2} = {1'b0, 4'($urandom)};
        k = $urandom_range(9, 2);
        wr(1, 16'(k));
        @(negedge core_clk) trigger[1] = 1'b1;
        @(negedge core_clk) trigger[1] = 1'b0;
        for (n = 0; n < 200 && general_pin_1 === 1'b1; n++)
            @(negedge core_clk);
        chk((n >= 16 * k - 16 && n <= 16 * k) ? 16'(k) : 16'(n), 16'(k));
        $display("one shot done");
        print_verdict();
    end
endmodule : testbench
